// [src/pbmc_pkg.sv]
// Shared constants and carrier types for the basic mode control block
`default_nettype none

package pbmc_pkg;

  // ==========================================================
  // Register map (byte addresses on the register bus)
  // ==========================================================
  localparam logic [7:0] BMC_OFFSET = 8'h00; // Basic mode control
  localparam logic [7:0] CFG_OFFSET = 8'h04; // Pin configuration
  localparam logic [7:0] STAT_OFFSET = 8'h08; // Live block state

  // ==========================================================
  // Field positions of basic_mode_control
  // ==========================================================
  localparam int SOFT_RESET_BIT = 15;
  localparam int LOOPBACK_BIT = 14;
  localparam int SPEED_BIT = 13;
  localparam int NEG_EN_BIT = 12;
  localparam int POWER_DOWN_BIT = 11;
  localparam int ISOLATE_BIT = 10;
  localparam int DUPLEX_BIT = 8;
  localparam int SPARE_BIT = 7;

  // Field positions of the configuration and status words
  localparam int PIN_PD_EN_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PD_BIT = 1;
  localparam int STAT_LINK_BIT = 2;
  localparam int STAT_PIN_BIT = 3;

  // ==========================================================
  // Reset values and fixed read-only indications
  // ==========================================================
  localparam logic [15:0] BMC_RESET = 16'h2100;
  localparam logic SPEED_FIXED = 1'h1; // Always 100 Mbps
  localparam logic NEG_EN_FIXED = 1'h0; // No negotiation
  localparam logic DUPLEX_FIXED = 1'h1; // Always full duplex
  localparam logic PIN_PD_EN_RESET = 1'h0;

  // ==========================================================
  // Timing and bus encodings
  // ==========================================================
  localparam logic [4:0] SOFT_RESET_CYCLES = 5'h10; // Reset hold
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // Nibble-wide MAC data with its valid strobe
  typedef struct packed {
    logic [3:0] data;
    logic valid;
  } pbmc_mii_t;

endpackage

`default_nettype wire

// [src/pbmc_basic_mode_control.sv]
// Basic mode control register with AHB-Lite slave and MAC data gating
// Behaviour
// R01: Soft reset holds logic, restores defaults, self-clears
// R02: Loopback returns MAC transmit data to receive
// R03: No link-up indication during loopback
// R04: Speed bit read-only, always one
// R05: Negotiation enable read-only, always zero
// R06: Power-down stops functions, registers stay accessible
// R07: Active-low pin input sets power-down bit
// R08: Isolate disconnects MAC data, management stays
// R09: Duplex bit read-only, always one
// R10: Register at address zero, resets to 2100h
// R11: Reserved bits zero; spare bit stores writes
`default_nettype none

module pbmc_basic_mode_control #(
  parameter int ADDR_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire pbmc_pkg::pbmc_mii_t mac_tx,
  input wire pbmc_pkg::pbmc_mii_t line_rx,
  input wire logic line_link_ok,
  input wire logic pd_pin_n,
  output pbmc_pkg::pbmc_mii_t mac_rx,
  output pbmc_pkg::pbmc_mii_t line_tx,
  output logic link_up,
  output logic power_down,
  output logic isolate_active,
  output logic digital_reset_n
);
  import pbmc_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  logic mac_side_loopback; // Transmit-to-receive return path
  logic pd_request; // Software or pin power-down
  logic isolate; // MAC data disconnect
  logic spare; // Writable reserved storage
  logic pin_pd_en; // Pin acts as power-down input
  logic [4:0] rst_cnt; // Remaining soft reset cycles
  logic wr_pend; // Write data phase pending
  logic [ADDR_W-1:0] wr_addr; // Address of pending write

  // Next values
  logic next_mac_side_loopback;
  logic next_pd_request;
  logic next_isolate;
  logic next_spare;
  logic next_pin_pd_en;
  logic [4:0] next_rst_cnt;
  logic next_wr_pend;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic [15:0] next_bmc; // Read image after this cycle

  // Helpers
  logic addr_ok; // Valid address phase accepted
  logic busy; // Soft reset in progress
  logic pin_pd; // Pin currently requests power-down
  logic wr_bmc;
  logic wr_cfg;

  // Datapath next values
  pbmc_mii_t next_mac_rx;
  pbmc_mii_t next_line_tx;
  logic next_link_up;
  logic next_power_down;
  logic next_isolate_active;
  logic next_digital_reset_n;

  // Size is not checked: only whole-word accesses are expected
  assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign busy = (rst_cnt != 5'h00);
  assign pin_pd = pin_pd_en & ~pd_pin_n;
  assign wr_bmc = wr_pend & (wr_addr == ADDR_W'(BMC_OFFSET));
  assign wr_cfg = wr_pend & (wr_addr == ADDR_W'(CFG_OFFSET));

  // ==========================================================
  // Register next-state logic
  // ==========================================================
  // Writes land in the data phase; control and configuration reads are built from the
  // next values so a read right after a write sees new data; status reads use current state
  always_comb
  begin
    next_mac_side_loopback = mac_side_loopback;
    next_pd_request = pd_request;
    next_isolate = isolate;
    next_spare = spare;
    next_pin_pd_en = pin_pd_en;
    next_rst_cnt = rst_cnt;
    next_wr_pend = addr_ok & hwrite;
    next_wr_addr = addr_ok ? haddr : wr_addr;
    // Plain register writes
    if (wr_bmc)
    begin
      next_mac_side_loopback = hwdata[LOOPBACK_BIT];
      next_pd_request = hwdata[POWER_DOWN_BIT];
      next_isolate = hwdata[ISOLATE_BIT];
      // R11: spare bit stores
      next_spare = hwdata[SPARE_BIT];
    end
    if (wr_cfg)
    begin
      next_pin_pd_en = hwdata[PIN_PD_EN_BIT];
    end
    // R01: write-one starts reset
    if (wr_bmc && hwdata[SOFT_RESET_BIT] && !busy)
    begin
      // Defaults beat the other fields of the same write
      next_rst_cnt = SOFT_RESET_CYCLES;
      next_mac_side_loopback = BMC_RESET[LOOPBACK_BIT];
      next_pd_request = BMC_RESET[POWER_DOWN_BIT];
      next_isolate = BMC_RESET[ISOLATE_BIT];
      next_spare = BMC_RESET[SPARE_BIT];
    end
    // R01: hold defaults, count down
    if (busy)
    begin
      // Basic mode control writes during the reset window are overridden
      next_rst_cnt = rst_cnt - 5'h01;
      next_mac_side_loopback = BMC_RESET[LOOPBACK_BIT];
      next_pd_request = BMC_RESET[POWER_DOWN_BIT];
      next_isolate = BMC_RESET[ISOLATE_BIT];
      next_spare = BMC_RESET[SPARE_BIT];
    end
    // R07: pin sets the bit
    if (pin_pd)
    begin
      // Set wins over any clearing write in the same cycle
      next_pd_request = 1'h1;
    end
    // R04: speed fixed one
    // R05: negotiation fixed zero
    // R09: duplex fixed one
    // R11: reserved bits zero
    next_bmc = 16'h0000;
    next_bmc[SOFT_RESET_BIT] = (next_rst_cnt != 5'h00);
    next_bmc[LOOPBACK_BIT] = next_mac_side_loopback;
    next_bmc[SPEED_BIT] = SPEED_FIXED;
    next_bmc[NEG_EN_BIT] = NEG_EN_FIXED;
    next_bmc[POWER_DOWN_BIT] = next_pd_request;
    next_bmc[ISOLATE_BIT] = next_isolate;
    next_bmc[DUPLEX_BIT] = DUPLEX_FIXED;
    next_bmc[SPARE_BIT] = next_spare;
    // Read mux; unmapped addresses read zero
    next_hrdata = 32'h0000_0000;
    if (addr_ok && !hwrite)
    begin
      // R10: register at address zero
      if (haddr == ADDR_W'(BMC_OFFSET))
      begin
        next_hrdata[15:0] = next_bmc;
      end
      else if (haddr == ADDR_W'(CFG_OFFSET))
      begin
        next_hrdata[PIN_PD_EN_BIT] = next_pin_pd_en;
      end
      else if (haddr == ADDR_W'(STAT_OFFSET))
      begin
        next_hrdata[STAT_BUSY_BIT] = busy;
        next_hrdata[STAT_PD_BIT] = power_down;
        next_hrdata[STAT_LINK_BIT] = link_up;
        next_hrdata[STAT_PIN_BIT] = pd_pin_n;
      end
      else
      begin
        next_hrdata = 32'h0000_0000;
      end
    end
  end

  // R10: reset value 2100h
  // R11: reserved read zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mac_side_loopback <= BMC_RESET[LOOPBACK_BIT];
      pd_request <= BMC_RESET[POWER_DOWN_BIT];
      isolate <= BMC_RESET[ISOLATE_BIT];
      spare <= BMC_RESET[SPARE_BIT];
      pin_pd_en <= PIN_PD_EN_RESET;
      rst_cnt <= 5'h00;
      wr_pend <= 1'h0;
      wr_addr <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'h1;
      hresp <= HRESP_OKAY;
    end
    else
    begin
      mac_side_loopback <= next_mac_side_loopback;
      pd_request <= next_pd_request;
      isolate <= next_isolate;
      spare <= next_spare;
      pin_pd_en <= next_pin_pd_en;
      rst_cnt <= next_rst_cnt;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      // Zero wait states, always OKAY
      hreadyout <= 1'h1;
      hresp <= HRESP_OKAY;
    end
  end

  // ==========================================================
  // MAC data path and indications
  // ==========================================================
  // One register stage on every path keeps outputs glitch-free
  always_comb
  begin
    // R06: power-down from bit
    // R07: pin OR-ed in
    next_power_down = pd_request | pin_pd;
    // R08: isolate from MAC
    next_isolate_active = isolate;
    // R01: digital logic held
    next_digital_reset_n = ~busy;
    next_mac_rx = '0;
    next_line_tx = '0;
    // R06: functions stopped
    // R08: data lines quiet
    if (busy || next_power_down || isolate)
    begin
      next_mac_rx = '0;
      next_line_tx = '0;
    end
    // R02: transmit returns to receive
    else if (mac_side_loopback)
    begin
      // Line transmit stays quiet so looped frames stay local
      next_mac_rx = mac_tx;
      next_line_tx = '0;
    end
    else
    begin
      next_mac_rx = line_rx;
      next_line_tx = mac_tx;
    end
    // R03: no link in loopback
    next_link_up = line_link_ok & ~mac_side_loopback & ~busy
      & ~next_power_down;
  end

  // Output registers for the data path
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mac_rx <= '0;
      line_tx <= '0;
      link_up <= 1'h0;
      power_down <= 1'h0;
      isolate_active <= 1'h0;
      digital_reset_n <= 1'h0;
    end
    else
    begin
      mac_rx <= next_mac_rx;
      line_tx <= next_line_tx;
      link_up <= next_link_up;
      power_down <= next_power_down;
      isolate_active <= next_isolate_active;
      digital_reset_n <= next_digital_reset_n;
    end
  end

endmodule

`default_nettype wire

// [verif/pbmc_checker.sv]
// Port-level checks on the basic mode control block
`default_nettype none

module pbmc_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire pbmc_pkg::pbmc_mii_t mac_tx,
  input wire pbmc_pkg::pbmc_mii_t line_rx,
  input wire logic line_link_ok,
  input wire pbmc_pkg::pbmc_mii_t mac_rx,
  input wire pbmc_pkg::pbmc_mii_t line_tx,
  input wire logic link_up,
  input wire logic power_down,
  input wire logic isolate_active,
  input wire logic digital_reset_n
);
  import pbmc_pkg::*;

  // ========================================================
  // Checks
  // ========================================================
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_rx_source: assert property (mac_rx != '0 |->
    mac_rx == $past(line_rx) || mac_rx == $past(mac_tx))
    else $error("mac_rx from no source");
  a_tx_source: assert property (line_tx != '0 |->
    line_tx == $past(mac_tx)) else $error("line_tx mismatch");
  a_link_raw: assert property (link_up |->
    $past(line_link_ok)) else $error("link_up without raw link");
  a_rst_nolink: assert property (!digital_reset_n |->
    !link_up) else $error("link_up during soft reset");
  a_rst_len: assert property ($fell(digital_reset_n) |->
    ##15 !digital_reset_n ##1 digital_reset_n)
    else $error("soft reset length wrong");
  a_pd_quiet: assert property (power_down && $past(power_down)
    |-> mac_rx == '0 && line_tx == '0 && !link_up)
    else $error("traffic while powered down");
  a_iso_quiet: assert property (
    isolate_active && $past(isolate_active) |->
    mac_rx == '0 && line_tx == '0) else $error("traffic in isolate");
  a_bus_ready: assert property (hreadyout && !hresp)
    else $error("register bus not ready or error");

  // Main scenarios reached
  c_pd: cover property (power_down);
  c_iso: cover property (isolate_active);
  c_srst: cover property ($fell(digital_reset_n));
endmodule

bind pbmc_basic_mode_control pbmc_checker pbmc_checker_inst (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .mac_tx(mac_tx), .line_rx(line_rx),
  .line_link_ok(line_link_ok), .mac_rx(mac_rx), .line_tx(line_tx),
  .link_up(link_up), .power_down(power_down),
  .isolate_active(isolate_active), .digital_reset_n(digital_reset_n));

`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the basic mode control block
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pbmc_pkg::*;

  // ========================================================
  // Signals
  // ========================================================
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize; // Always a whole word
  logic [31:0] hwdata, hrdata, r;
  logic line_link_ok, pd_pin_n, link_up, power_down;
  logic isolate_active, digital_reset_n;
  pbmc_mii_t mac_tx, line_rx, mac_rx, line_tx;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;

  // The one slave's hreadyout is the bus's hready
  pbmc_basic_mode_control pbmc_basic_mode_control_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mac_tx(mac_tx), .line_rx(line_rx),
    .line_link_ok(line_link_ok), .pd_pin_n(pd_pin_n),
    .mac_rx(mac_rx), .line_tx(line_tx), .link_up(link_up),
    .power_down(power_down), .isolate_active(isolate_active),
    .digital_reset_n(digital_reset_n));

  // 25 MHz clock
  initial
  begin
    hclk = 1'h0;
    forever #20 hclk = ~hclk;
  end

  // ========================================================
  // Tasks
  // ========================================================
  task automatic give_verdict();
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single transfer; each phase ends at an edge with hready high
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    // Read data taken at the edge that ends the data phase
    r = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk(r, e);
  endtask

  // Let n edges pass, then look where outputs are settled
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask

  // ========================================================
  // Sequence
  // ========================================================
  initial
  begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 8'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mac_tx = '0;
    line_rx = '0;
    line_link_ok = 1'h0;
    pd_pin_n = 1'h1;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    rd(BMC_OFFSET, 32'h2100);
    rd(8'h0c, 32'h0);
    xfer(1'h1, 8'h0c, 32'hffff);
    rd(8'h0c, 32'h0);
    xfer(1'h1, BMC_OFFSET, 32'h7fff);
    rd(BMC_OFFSET, 32'h6d80);
    xfer(1'h1, BMC_OFFSET, 32'h0);
    rd(BMC_OFFSET, 32'h2100);
    // Normal traffic in both directions
    @(posedge hclk);
    mac_tx <= '{4'ha, 1'h1};
    line_rx <= '{4'h5, 1'h1};
    line_link_ok <= 1'h1;
    tick(2);
    chk(32'(line_tx), 32'(mac_tx));
    chk(32'(mac_rx), 32'(line_rx));
    chk(32'(link_up), 32'h1);
    xfer(1'h1, BMC_OFFSET, 32'h4000);
    tick(2);
    chk(32'(mac_rx), 32'(mac_tx));
    chk(32'(link_up), 32'h0);
    rd(BMC_OFFSET, 32'h6100);
    xfer(1'h1, BMC_OFFSET, 32'h0400);
    tick(2);
    chk(32'({mac_rx, line_tx}), 32'h0);
    chk(32'(isolate_active), 32'h1);
    rd(BMC_OFFSET, 32'h2500);
    xfer(1'h1, BMC_OFFSET, 32'h0800);
    tick(2);
    chk(32'({power_down, link_up}), 32'h2);
    rd(BMC_OFFSET, 32'h2900);
    xfer(1'h1, BMC_OFFSET, 32'h0);
    tick(2);
    chk(32'(power_down), 32'h0);
    // Pin as power-down input; bit stays after release
    xfer(1'h1, CFG_OFFSET, 32'h1);
    rd(CFG_OFFSET, 32'h1);
    @(posedge hclk);
    pd_pin_n <= 1'h0;
    tick(2);
    chk(32'(power_down), 32'h1);
    rd(STAT_OFFSET, 32'h2);
    @(posedge hclk);
    pd_pin_n <= 1'h1;
    rd(BMC_OFFSET, 32'h2900);
    xfer(1'h1, CFG_OFFSET, 32'h0);
    xfer(1'h1, BMC_OFFSET, 32'h0);
    rd(BMC_OFFSET, 32'h2100);
    // Soft reset clears writable fields, ignores writes
    xfer(1'h1, BMC_OFFSET, 32'h0480);
    xfer(1'h1, BMC_OFFSET, 32'h8480);
    rd(BMC_OFFSET, 32'ha100);
    tick(0);
    chk(32'(digital_reset_n), 32'h0);
    chk(32'(isolate_active), 32'h0);
    xfer(1'h1, BMC_OFFSET, 32'h4000);
    tick(20);
    chk(32'(digital_reset_n), 32'h1);
    rd(BMC_OFFSET, 32'h2100);
    give_verdict();
  end

  // Hang guard, far above the roughly 120 cycles needed
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      give_verdict();
    end
  end
endmodule

`default_nettype wire
